// >>> cil_pkg.sv
// Constants and types of the interpolator and soft limiter back end
package cil_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CONTROL    = 8'h02;
  localparam logic [7:0] A_STATUS     = 8'h03;
  localparam logic [7:0] A_MODE       = 8'h80;
  localparam logic [7:0] A_COEF0      = 8'h82;
  localparam logic [7:0] A_COEF_LAST  = 8'hA9;
  localparam logic [7:0] A_LENGTH     = 8'hC0;
  localparam logic [7:0] A_TSQD       = 8'hC1;
  localparam logic [7:0] A_TAPER0     = 8'hC2;
  localparam logic [7:0] A_TAPER_LAST = 8'hD1;
  localparam logic [7:0] A_SHIFT      = 8'hD2;
  localparam logic [7:0] A_INVG0      = 8'hD3;
  localparam logic [7:0] A_INVG_LAST  = 8'hF2;
  localparam logic [7:0] A_GAIN_A     = 8'hF3;
  localparam logic [7:0] A_GAIN_B     = 8'hF4;
  localparam logic [7:0] A_OFF_I0     = 8'hF5;
  localparam logic [7:0] A_OFF_Q0     = 8'hF6;
  localparam logic [7:0] A_OFF_I1     = 8'hF7;
  localparam logic [7:0] A_OFF_Q1     = 8'hF8;
  // ----------------------------------------------------------------
  // Fields, sizes and reset values
  // ----------------------------------------------------------------
  localparam int          NCOEF      = 40;
  localparam int          NTAPER     = 16;
  localparam int          NINVG      = 32;
  localparam int          GAIN_FRAC  = 13;
  localparam int          COEF_FRAC  = 15;
  localparam logic [15:0] RST_COEF0  = 16'h8000;
  localparam logic [15:0] RST_TSQD   = 16'hFFFF;
  localparam logic [3:0]  RST_SHIFT  = 4'hF;
  localparam logic [5:0]  SHIFT_BIAS = 6'h11;
  localparam logic [16:0] TAPER_ONE  = 17'h1_0000;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_CPLX_X2 = 2'b00,
    MODE_REAL_X2 = 2'b01,
    MODE_REAL_X4 = 2'b10,
    MODE_REAL_X4B = 2'b11
  } cil_mode_t;
  typedef enum logic {
    LIM_IDLE   = 1'b0,
    LIM_ACTIVE = 1'b1
  } cil_lim_t;
  typedef struct packed {
    logic signed [15:0] i;
    logic signed [15:0] q;
  } cil_iq_t;
  typedef struct packed {
    logic                     interp_en;
    logic                     limit_en;
    cil_mode_t                mode;
    logic [NCOEF-1:0][15:0]   coef;
    logic [1:0]               len;
    logic [15:0]              tsqd;
    logic [NTAPER-1:0][15:0]  taper;
    logic [3:0]               shift;
    logic [NINVG-1:0][15:0]   invg;
    logic [15:0]              gain_a;
    logic [15:0]              gain_b;
    logic [3:0][15:0]         offs;
    logic [1:0]               zs;
    cil_iq_t [NCOEF-1:0]      dl;
    logic                     dl_v;
    cil_iq_t                  fir;
    logic                     fir_v;
    cil_iq_t [NTAPER-1:0]     ld;
    cil_lim_t                 lim;
    logic [5:0]               pos;
    logic [15:0]              depth;
    logic [1:0]               ph;
    logic [15:0]              rdata;
    logic [15:0]              out_a;
    logic [15:0]              out_b;
    logic                     out_v;
  } cil_state_t;
endpackage

// >>> cil_stream_partner.sv
// Upstream sample source and downstream output capture
`timescale 1ns/10ps
module cil_stream_partner (
  input  wire logic        clk,
  input  wire logic        rst_n,
  output cil_pkg::cil_iq_t sample,
  output logic             valid,
  input  wire logic [15:0] out_a,
  input  wire logic [15:0] out_b,
  input  wire logic        out_valid
);
  int          cyc;
  int          t_in;
  int          t_out;
  int          n;
  logic [15:0] cap_a [256];
  logic [15:0] cap_b [256];

  initial begin
    sample = '0;
    valid  = 1'b0;
  end

  // Data lines carry the inverse once the strobe is gone
  task automatic send(input cil_pkg::cil_iq_t x, input int gap);
    @(posedge clk);
    sample <= x;
    valid  <= 1'b1;
    @(posedge clk);
    sample <= cil_pkg::cil_iq_t'(~x);
    valid  <= 1'b0;
    repeat (gap) @(posedge clk);
  endtask

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc <= 0;
      n   <= 0;
    end else begin
      cyc <= cyc + 1;
      if (valid) begin
        t_in <= cyc;
      end
      if (out_valid) begin
        cap_a[n[7:0]] <= out_a;
        cap_b[n[7:0]] <= out_b;
        t_out         <= cyc;
        n             <= n + 1;
      end
    end
  end
endmodule

// >>> cil_top.sv
// Output back end: interpolator, soft limiter, output gain and offset
`timescale 1ns/10ps

module cil_top (
  input  wire logic                 REF_CLK,
  input  wire logic                 RESETN,
  input  wire logic [7:0]           REG_ADDR,
  input  wire logic [15:0]          REG_WDATA,
  input  wire logic                 REG_WR,
  input  wire logic                 REG_RD,
  output logic      [15:0]          REG_RDATA,
  input  wire cil_pkg::cil_iq_t     IN_SAMPLE,
  input  wire logic                 IN_VALID,
  output logic      [15:0]          OUT_A,
  output logic      [15:0]          OUT_B,
  output logic                      OUT_VALID
);

  cil_pkg::cil_state_t st_q;
  cil_pkg::cil_state_t st_d;

  logic               coef_hit;
  logic               taper_hit;
  logic               invg_hit;
  logic [7:0]         coef_off;
  logic [7:0]         taper_off;
  logic [7:0]         invg_off;
  logic [15:0]        rd_mux;
  logic [1:0]         zs_len;
  logic               stuff;
  cil_pkg::cil_iq_t   fir_in;
  logic signed [47:0] acc_i;
  logic signed [47:0] acc_q;
  logic [31:0]        mag;
  logic [31:0]        excess;
  logic [31:0]        idx_full;
  logic [4:0]         idx;
  logic [4:0]         n;
  logic [4:0]         nm1;
  logic [5:0]         two_n;
  logic [5:0]         mir;
  logic               peak_hit;
  logic               act_now;
  logic [5:0]         cur_pos;
  logic [15:0]        depth_now;
  logic [16:0]        w;
  logic [32:0]        wd;
  logic [16:0]        lgain;
  cil_pkg::cil_iq_t   lim_x;
  logic               lim_v;
  logic signed [33:0] pi;
  logic signed [33:0] pq;
  cil_pkg::cil_iq_t   lim_out;
  logic               real_mode;
  logic signed [16:0] rs;
  logic signed [16:0] sel_a;
  logic signed [16:0] sel_b;
  logic signed [47:0] ta;
  logic signed [47:0] tb;

  function automatic logic [15:0] sat16(input logic signed [47:0] v);
    if (v > 48'sh0000_0000_7FFF) begin
      sat16 = 16'h7FFF;
    end else if (v < -48'sh0000_0000_8000) begin
      sat16 = 16'h8000;
    end else begin
      sat16 = v[15:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  always_comb begin
    coef_hit  = (REG_ADDR >= cil_pkg::A_COEF0) && (REG_ADDR <= cil_pkg::A_COEF_LAST);
    taper_hit = (REG_ADDR >= cil_pkg::A_TAPER0) && (REG_ADDR <= cil_pkg::A_TAPER_LAST);
    invg_hit  = (REG_ADDR >= cil_pkg::A_INVG0) && (REG_ADDR <= cil_pkg::A_INVG_LAST);
    coef_off  = REG_ADDR - cil_pkg::A_COEF0;
    taper_off = REG_ADDR - cil_pkg::A_TAPER0;
    invg_off  = REG_ADDR - cil_pkg::A_INVG0;
  end

  // Unmapped addresses and reserved bits read as zero
  always_comb begin
    rd_mux = 16'h0000;
    if (coef_hit) begin
      rd_mux = st_q.coef[coef_off[5:0]];
    end else if (taper_hit) begin
      rd_mux = st_q.taper[taper_off[3:0]];
    end else if (invg_hit) begin
      rd_mux = st_q.invg[invg_off[4:0]];
    end else begin
      case (REG_ADDR)
        cil_pkg::A_CONTROL: rd_mux = {10'h000, st_q.limit_en, st_q.interp_en, 4'h0};
        cil_pkg::A_STATUS:  rd_mux = {9'h000, st_q.pos, st_q.lim};
        cil_pkg::A_MODE:    rd_mux = {14'h0000, st_q.mode};
        cil_pkg::A_LENGTH:  rd_mux = {14'h0000, st_q.len};
        cil_pkg::A_TSQD:    rd_mux = st_q.tsqd;
        cil_pkg::A_SHIFT:   rd_mux = {12'h000, st_q.shift};
        cil_pkg::A_GAIN_A:  rd_mux = st_q.gain_a;
        cil_pkg::A_GAIN_B:  rd_mux = st_q.gain_b;
        cil_pkg::A_OFF_I0:  rd_mux = st_q.offs[0];
        cil_pkg::A_OFF_Q0:  rd_mux = st_q.offs[1];
        cil_pkg::A_OFF_I1:  rd_mux = st_q.offs[2];
        cil_pkg::A_OFF_Q1:  rd_mux = st_q.offs[3];
        default:            rd_mux = 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interpolator
  // ----------------------------------------------------------------
  always_comb begin
    // Zeros stuffed after each input sample
    if (!st_q.interp_en) begin
      zs_len = 2'h0;
    end else if (st_q.mode[1]) begin
      zs_len = 2'h3;
    end else begin
      zs_len = 2'h1;
    end
    stuff  = IN_VALID || (st_q.zs != 2'h0);
    fir_in = IN_VALID ? IN_SAMPLE : '0;
    acc_i  = '0;
    acc_q  = '0;
    // Table is used whether or not interpolation is enabled
    for (int k = 0; k < cil_pkg::NCOEF; k++) begin
      acc_i = acc_i + 48'(signed'(st_q.coef[k]) * st_q.dl[k].i);
      acc_q = acc_q + 48'(signed'(st_q.coef[k]) * st_q.dl[k].q);
    end
  end

  // ----------------------------------------------------------------
  // Soft limiter
  // ----------------------------------------------------------------
  always_comb begin
    mag      = 32'(st_q.fir.i * st_q.fir.i) + 32'(st_q.fir.q * st_q.fir.q);
    excess   = mag - {st_q.tsqd, 16'h0000};
    idx_full = excess >> (cil_pkg::SHIFT_BIAS + {2'b00, st_q.shift});
    idx      = (|idx_full[31:5]) ? 5'h1F : idx_full[4:0];
    unique case (st_q.len)
      2'b00: n = 5'h00;
      2'b01: n = 5'h04;
      2'b10: n = 5'h08;
      2'b11: n = 5'h10;
    endcase
    nm1   = n - 5'h01;
    two_n = {n, 1'b0};
    // Threshold uses the top half of the squared magnitude
    peak_hit  = st_q.fir_v && st_q.limit_en && (n != 5'h00) && (st_q.lim == cil_pkg::LIM_IDLE)
                && (mag[31:16] > st_q.tsqd);
    act_now   = peak_hit || (st_q.lim == cil_pkg::LIM_ACTIVE);
    cur_pos   = peak_hit ? 6'h00 : st_q.pos;
    depth_now = peak_hit ? st_q.invg[idx] : st_q.depth;
    mir       = two_n - cur_pos;
    // Entries before the peak, implied unity at it, mirrored after it
    if (cur_pos < {1'b0, n}) begin
      w = {1'b0, st_q.taper[cur_pos[3:0]]};
    end else if (cur_pos == {1'b0, n}) begin
      w = cil_pkg::TAPER_ONE;
    end else begin
      w = {1'b0, st_q.taper[mir[3:0]]};
    end
    wd    = w * depth_now;
    lgain = cil_pkg::TAPER_ONE - wd[32:16];
    // Delayed path only when limiting is on
    if (st_q.limit_en && (n != 5'h00)) begin
      lim_x = st_q.ld[nm1[3:0]];
    end else begin
      lim_x = st_q.fir;
    end
    lim_v = st_q.fir_v;
    pi    = lim_x.i * signed'({1'b0, lgain});
    pq    = lim_x.q * signed'({1'b0, lgain});
    if (act_now) begin
      lim_out.i = pi[31:16];
      lim_out.q = pq[31:16];
    end else begin
      lim_out = lim_x;
    end
  end

  // ----------------------------------------------------------------
  // Output mixing, gain and offset
  // ----------------------------------------------------------------
  always_comb begin
    real_mode = st_q.interp_en && (st_q.mode != cil_pkg::MODE_CPLX_X2);
    unique case (st_q.ph)
      2'h0: rs = {lim_out.i[15], lim_out.i};
      2'h1: rs = -{lim_out.q[15], lim_out.q};
      2'h2: rs = -{lim_out.i[15], lim_out.i};
      2'h3: rs = {lim_out.q[15], lim_out.q};
    endcase
    sel_a = real_mode ? rs : {lim_out.i[15], lim_out.i};
    sel_b = real_mode ? rs : {lim_out.q[15], lim_out.q};
    // Gain and offset are always applied
    ta = (48'(sel_a * signed'(st_q.gain_a)) >>> cil_pkg::GAIN_FRAC) + 48'(signed'(st_q.offs[0]));
    tb = (48'(sel_b * signed'(st_q.gain_b)) >>> cil_pkg::GAIN_FRAC)
         + 48'(signed'(real_mode ? st_q.offs[2] : st_q.offs[1]));
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d       = st_q;
    st_d.rdata = REG_RD ? rd_mux : 16'h0000;
    if (REG_WR) begin
      if (coef_hit) begin
        st_d.coef[coef_off[5:0]] = REG_WDATA;
      end else if (taper_hit) begin
        st_d.taper[taper_off[3:0]] = REG_WDATA;
      end else if (invg_hit) begin
        st_d.invg[invg_off[4:0]] = REG_WDATA;
      end else begin
        case (REG_ADDR)
          cil_pkg::A_CONTROL: begin
            st_d.interp_en = REG_WDATA[4];
            st_d.limit_en  = REG_WDATA[5];
          end
          cil_pkg::A_MODE:   st_d.mode   = cil_pkg::cil_mode_t'(REG_WDATA[1:0]);
          cil_pkg::A_LENGTH: st_d.len    = REG_WDATA[1:0];
          cil_pkg::A_TSQD:   st_d.tsqd   = REG_WDATA;
          cil_pkg::A_SHIFT:  st_d.shift  = REG_WDATA[3:0];
          cil_pkg::A_GAIN_A: st_d.gain_a = REG_WDATA;
          cil_pkg::A_GAIN_B: st_d.gain_b = REG_WDATA;
          cil_pkg::A_OFF_I0: st_d.offs[0] = REG_WDATA;
          cil_pkg::A_OFF_Q0: st_d.offs[1] = REG_WDATA;
          cil_pkg::A_OFF_I1: st_d.offs[2] = REG_WDATA;
          cil_pkg::A_OFF_Q1: st_d.offs[3] = REG_WDATA;
          default: st_d.rdata = st_d.rdata;
        endcase
      end
    end
    // Interpolator delay line with zero stuffing
    if (IN_VALID) begin
      st_d.zs = zs_len;
    end else if (st_q.zs != 2'h0) begin
      st_d.zs = st_q.zs - 2'h1;
    end
    if (stuff) begin
      st_d.dl = {st_q.dl[cil_pkg::NCOEF-2:0], fir_in};
    end
    st_d.dl_v  = stuff;
    st_d.fir_v = st_q.dl_v;
    st_d.fir.i = sat16(-(acc_i >>> cil_pkg::COEF_FRAC));
    st_d.fir.q = sat16(-(acc_q >>> cil_pkg::COEF_FRAC));
    // Limiter window tracking
    if (st_q.fir_v) begin
      st_d.ld = {st_q.ld[cil_pkg::NTAPER-2:0], st_q.fir};
    end
    if (peak_hit) begin
      st_d.lim   = cil_pkg::LIM_ACTIVE;
      st_d.depth = depth_now;
    end
    if (act_now && lim_v) begin
      st_d.pos = cur_pos + 6'h01;
      if (cur_pos >= two_n) begin
        st_d.lim = cil_pkg::LIM_IDLE;
        st_d.pos = 6'h00;
      end
    end
    if (!st_q.limit_en) begin
      st_d.lim = cil_pkg::LIM_IDLE;
      st_d.pos = 6'h00;
    end
    // Output stage
    st_d.out_v = lim_v;
    if (lim_v) begin
      st_d.out_a = sat16(ta);
      st_d.out_b = sat16(tb);
      st_d.ph    = real_mode ? st_q.ph + 2'h1 : 2'h0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_q         <= '0;  // Gains and offsets zero
      st_q.coef[0] <= cil_pkg::RST_COEF0;
      st_q.tsqd    <= cil_pkg::RST_TSQD;
      st_q.shift   <= cil_pkg::RST_SHIFT;
    end else begin
      st_q <= st_d;
    end
  end

  assign REG_RDATA = st_q.rdata;
  assign OUT_A     = st_q.out_a;
  assign OUT_B     = st_q.out_b;
  assign OUT_VALID = st_q.out_v;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);

  a_coef_readback: assert property (
    (REG_WR && coef_hit) ##1 (REG_RD && !REG_WR && REG_ADDR == $past(REG_ADDR))
    |=> REG_RDATA == $past(REG_WDATA, 2)) else $error("coefficient readback mismatch");
  a_mode_reserved: assert property (
    REG_RD && REG_ADDR == cil_pkg::A_MODE |=> REG_RDATA[15:2] == 14'h0000)
    else $error("reserved mode bits not zero");
  a_shift_reserved: assert property (
    REG_RD && REG_ADDR == cil_pkg::A_SHIFT |=> REG_RDATA[15:4] == 12'h000)
    else $error("reserved shift bits not zero");
  a_stuff_by4: assert property (
    IN_VALID && st_q.interp_en && st_q.mode[1] ##1 !IN_VALID [*2]
    |-> st_q.zs == 2'h2 ##1 st_q.zs == 2'h1) else $error("by-4 zero stuffing count wrong");
  a_bypass_idle: assert property (
    !st_q.limit_en |=> st_q.lim == cil_pkg::LIM_IDLE) else $error("limiter active while bypassed");
  a_peak_start: assert property (
    peak_hit |=> st_q.lim == cil_pkg::LIM_ACTIVE && st_q.depth == $past(st_q.invg[idx]))
    else $error("peak did not start limiting window");
  a_window_bound: assert property (
    st_q.lim == cil_pkg::LIM_ACTIVE && $stable(st_q.len) |-> st_q.pos <= two_n)
    else $error("limiting window overran");
  a_center_unity: assert property (
    act_now && cur_pos == {1'b0, n}
    |-> w == cil_pkg::TAPER_ONE && lgain == cil_pkg::TAPER_ONE - {1'b0, depth_now}) else $error("centre taper not unity");
  a_zero_gain: assert property (
    OUT_VALID && $past(st_q.gain_a) == 16'h0000 && $past(st_q.offs[0]) == 16'h0000 |-> OUT_A == 16'h0000)
    else $error("zero gain gave non-zero output");
  a_offset_path: assert property (
    OUT_VALID && !$past(real_mode) && $past(st_q.gain_b) == 16'h0000 |-> OUT_B == $past(st_q.offs[1]))
    else $error("offset not applied to output");

  c_peak: cover property (peak_hit ##[1:40] st_q.lim == cil_pkg::LIM_IDLE);
  c_real_out: cover property (OUT_VALID && $past(real_mode) && st_q.ph == 2'h3);
  c_coef_write: cover property (REG_WR && coef_hit ##1 REG_RD);

endmodule

// >>> cil_top_bench.sv
// Self-checking bench of the interpolator and soft limiter back end
`timescale 1ns/10ps
module cil_top_bench;
  logic             REF_CLK;
  logic             RESETN;
  logic [7:0]       REG_ADDR;
  logic [15:0]      REG_WDATA;
  logic             REG_WR;
  logic             REG_RD;
  logic [15:0]      REG_RDATA;
  cil_pkg::cil_iq_t IN_SAMPLE;
  logic             IN_VALID;
  logic [15:0]      OUT_A;
  logic [15:0]      OUT_B;
  logic             OUT_VALID;
  int               err_count;
  int               cmp_count;
  logic [15:0]      rv;

  cil_top i_dut (.REF_CLK(REF_CLK), .RESETN(RESETN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .IN_SAMPLE(IN_SAMPLE),
    .IN_VALID(IN_VALID), .OUT_A(OUT_A), .OUT_B(OUT_B), .OUT_VALID(OUT_VALID));
  cil_stream_partner i_src (.clk(REF_CLK), .rst_n(RESETN), .sample(IN_SAMPLE), .valid(IN_VALID),
    .out_a(OUT_A), .out_b(OUT_B), .out_valid(OUT_VALID));

  initial begin
    REF_CLK = 1'b0;
    forever #50 REF_CLK = ~REF_CLK;
  end
  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge REF_CLK);
    REG_ADDR  <= a;
    REG_WDATA <= d;
    REG_WR    <= 1'b1;
    @(posedge REF_CLK);
    REG_WR    <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    @(posedge REF_CLK);
    REG_ADDR <= a;
    REG_RD   <= 1'b1;
    @(posedge REF_CLK);
    REG_RD   <= 1'b0;
    #1;
    rv = REG_RDATA;
    check($sformatf("register %h", a), rv, e);
  endtask
  // Write then read back with no gap between the strobes
  task automatic wrchk(input logic [7:0] a, input logic [15:0] d);
    @(posedge REF_CLK);
    REG_ADDR  <= a;
    REG_WDATA <= d;
    REG_WR    <= 1'b1;
    @(posedge REF_CLK);
    REG_WR    <= 1'b0;
    REG_RD    <= 1'b1;
    @(posedge REF_CLK);
    REG_RD    <= 1'b0;
    #1;
    rv = REG_RDATA;
    check($sformatf("register %h", a), rv, d);
  endtask
  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rchk(cil_pkg::A_COEF0, 16'h8000);
    rchk(8'h83, 16'h0000);
    rchk(cil_pkg::A_COEF_LAST, 16'h0000);
    rchk(cil_pkg::A_TSQD, 16'hFFFF);
    rchk(cil_pkg::A_SHIFT, 16'h000F);
    rchk(cil_pkg::A_GAIN_A, 16'h0000);
    rchk(cil_pkg::A_GAIN_B, 16'h0000);
    rchk(cil_pkg::A_OFF_I0, 16'h0000);
    rchk(cil_pkg::A_OFF_Q1, 16'h0000);
    rchk(cil_pkg::A_MODE, 16'h0000);
    rchk(cil_pkg::A_LENGTH, 16'h0000);
    rchk(cil_pkg::A_TAPER0, 16'h0000);
    rchk(cil_pkg::A_INVG_LAST, 16'h0000);
    $display("test reset values done");
  endtask
  task automatic t_regs;
    wr(cil_pkg::A_MODE, 16'hFFFF);
    rchk(cil_pkg::A_MODE, 16'h0003);
    wr(cil_pkg::A_LENGTH, 16'hFFFE);
    rchk(cil_pkg::A_LENGTH, 16'h0002);
    wr(cil_pkg::A_SHIFT, 16'hFFF5);
    rchk(cil_pkg::A_SHIFT, 16'h0005);
    wrchk(cil_pkg::A_COEF_LAST, 16'h8001);
    wr(cil_pkg::A_COEF_LAST, 16'h0000);
    wr(8'h81, 16'hFFFF);
    rchk(8'h81, 16'h0000);
    wr(cil_pkg::A_CONTROL, 16'hFFCF);
    rchk(cil_pkg::A_CONTROL, 16'h0000);
    $display("test register access done");
  endtask
  task automatic t_path;
    i_src.send('{16'h1234, 16'h0100}, 4);
    check("out_a at zero gain", OUT_A, 16'h0000);
    wr(cil_pkg::A_GAIN_A, 16'h2000);
    wr(cil_pkg::A_GAIN_B, 16'hE000);
    wr(cil_pkg::A_OFF_I0, 16'h0010);
    i_src.send('{16'h1234, 16'h0100}, 4);
    check("out_a gain offset", OUT_A, 16'h1244);
    check("out_b negative gain", OUT_B, 16'hFF00);
    check("latency", 16'(i_src.t_out - i_src.t_in), 16'h0003);
    wr(cil_pkg::A_OFF_I0, 16'h0000);
    wr(cil_pkg::A_GAIN_B, 16'h2000);
    wr(cil_pkg::A_COEF0, 16'hC000);
    i_src.send('{16'h1234, 16'h0100}, 4);
    check("out_a coef in bypass", OUT_A, 16'h091A);
    check("out_b signed coef", OUT_B, 16'h0080);
    wr(cil_pkg::A_COEF0, 16'h8000);
    $display("test sample path done");
  endtask
  task automatic t_interp;
    int          n0;
    logic        ok;
    logic [15:0] a;
    logic [15:0] b;
    wr(cil_pkg::A_CONTROL, 16'h0010);
    wr(cil_pkg::A_OFF_I1, 16'h0001);
    for (int m = 0; m < 4; m++) begin
      wr(cil_pkg::A_MODE, 16'(m));
      n0 = i_src.n;
      i_src.send('{16'h0100, 16'h0200}, 10);
      check("interp outputs", 16'(i_src.n - n0), (m > 1) ? 16'h0004 : 16'h0002);
      a = i_src.cap_a[n0[7:0]];
      b = i_src.cap_b[n0[7:0]];
      ok = (m == 0) ? (a === 16'h0100 && b === 16'h0200) :
           (b === a + 16'h0001 && (a === 16'h0100 || a === 16'hFE00 || a === 16'hFF00 || a === 16'h0200));
      check("interp first output", {15'h0000, ok}, 16'h0001);
    end
    wr(cil_pkg::A_CONTROL, 16'h0000);
    wr(cil_pkg::A_MODE, 16'h0000);
    wr(cil_pkg::A_OFF_I1, 16'h0000);
    $display("test interpolation modes done");
  endtask
  // Taper entry 0 is zero so the window edges show the mirrored order
  task automatic t_lim_setup;
    wr(cil_pkg::A_TSQD, 16'h0010);
    for (int k = 1; k < 16; k++) wr(8'(cil_pkg::A_TAPER0 + 8'(k)), 16'h8000);
    for (int k = 0; k < 32; k++) wr(8'(cil_pkg::A_INVG0 + 8'(k)), 16'h8000);
    i_src.send('{16'h4000, 16'h0000}, 4);
    check("peak with limiter off", OUT_A, 16'h4000);
    $display("test limiter bypass done");
  endtask
  task automatic t_limit(input logic [1:0] code, input int nt);
    int          n0;
    int          pk;
    int          d;
    logic [15:0] x;
    logic [15:0] e;
    pk = nt + 2;
    wr(cil_pkg::A_LENGTH, {14'h0000, code});
    wr(cil_pkg::A_CONTROL, 16'h0020);
    n0 = i_src.n;
    for (int k = 0; k < 3 * nt + 6; k++) begin
      x = (k == pk) ? 16'h4000 : 16'h0100;
      i_src.send('{x, 16'h0000}, 0);
    end
    repeat (4) @(posedge REF_CLK);
    for (int j = nt; j < 3 * nt + 6; j++) begin
      d = j - nt - pk;
      if (d < 0) begin
        d = -d;
      end
      e = (d == 0) ? 16'h2000 : ((d < nt) ? 16'h00C0 : 16'h0100);
      check($sformatf("limited sample %0d", j), i_src.cap_a[8'(n0 + j)], e);
    end
    wr(cil_pkg::A_CONTROL, 16'h0000);
    $display("test limiter length %0d done", nt);
  endtask

  initial begin
    #2_000_000;
    err_count++;
    $display("watchdog expired");
    final_report;
  end
  initial begin
    err_count = 0;
    cmp_count = 0;
    RESETN    = 1'b0;
    REG_ADDR  = 8'h00;
    REG_WDATA = 16'h0000;
    REG_WR    = 1'b0;
    REG_RD    = 1'b0;
    repeat (10) @(posedge REF_CLK);
    RESETN <= 1'b1;
    t_reset;
    t_regs;
    t_path;
    t_interp;
    t_lim_setup;
    t_limit(2'b01, 4);
    t_limit(2'b10, 8);
    t_limit(2'b11, 16);
    final_report;
  end
endmodule
